// ### core/reset_cause_pkg.sv
// Constants shared by the reset-cause and forced-reset logic
package reset_cause_pkg;

  // ---------------------------------------------------------------
  // Data and address widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // ---------------------------------------------------------------
  // Register addresses (arbitrary placement on the CPU bus)
  // ---------------------------------------------------------------
  localparam logic [15:0] FLAGS_ADDR = 16'h1800;
  localparam logic [15:0] FORCE_ADDR = 16'h1801;

  // ---------------------------------------------------------------
  // Cause flag bit positions
  // ---------------------------------------------------------------
  localparam int POWER_ON_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int WATCHDOG_BIT = 5;
  localparam int ILL_OPCODE_BIT = 4;
  localparam int ILL_ADDRESS_BIT = 3;
  localparam int CLOCK_MODULE_BIT = 2;
  localparam int LOW_VOLTAGE_BIT = 1;
  localparam int FORCE_BIT = 0;

  // ---------------------------------------------------------------
  // Flag values per reset kind
  // ---------------------------------------------------------------
  localparam logic [7:0] POWER_ON_FLAGS = 8'h82;
  localparam logic [6:0] LOW_VOLTAGE_FLAGS = 7'h02;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Illegal address gaps
  // ---------------------------------------------------------------
  localparam logic [15:0] GAP1_LO = 16'h0470;
  localparam logic [15:0] GAP1_HI = 16'h17FF;
  localparam logic [15:0] GAP2_LO = 16'h1860;
  localparam logic [15:0] GAP2_HI = 16'hBFFF;

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  localparam int WDOG_CNT_W = 18;

endpackage

// ### core/reset_cause.sv
// Reset-cause flags, watchdog kick and debug-forced reset
`timescale 1ns/1ps
`default_nettype none

module reset_cause #(
  parameter int WDOG_W = reset_cause_pkg::WDOG_CNT_W,
  parameter logic [15:0] FLAGS_ADDR = reset_cause_pkg::FLAGS_ADDR,
  parameter logic [15:0] FORCE_ADDR = reset_cause_pkg::FORCE_ADDR
) (
  // Clock and system reset
  input wire logic clk,
  input wire logic sys_rst,
  // Reset sources from pins and analog
  input wire logic rst_pin_n,
  input wire logic power_on_detect,
  input wire logic low_voltage_detect,
  // Low-voltage and mode options
  input wire logic low_voltage_reset_enable,
  input wire logic low_voltage_halt_enable,
  input wire logic watchdog_enable_option,
  input wire logic halt_mode_enable,
  input wire logic background_mode_enable,
  // Instruction decode events
  input wire logic opcode_unimplemented,
  input wire logic halt_instruction,
  input wire logic background_entry_instruction,
  // Clock module request
  input wire logic clock_module_reset_req,
  // CPU and background bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_bdm,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Reset request to the system controller
  output logic mcu_reset_req
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] pwr_sync;
    logic [1:0] lowv_sync;
    logic in_rst;
    logic reset_req;
    logic [7:0] pending;
    logic [7:0] flags;
    logic [WDOG_W-1:0] wdog_cnt;
    logic [7:0] rdata;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic release_now;
  logic access;
  logic in_gap;
  logic ev_pin;
  logic ev_wdog;
  logic ev_bad_opcode;
  logic ev_bad_addr;
  logic ev_clk;
  logic ev_lowv;
  logic ev_pwr;
  logic ev_force;
  logic wdog_kick;
  logic [7:0] events;

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  // First cycle out of reset latches the flags
  assign release_now = st_ff.in_rst & ~sys_rst;
  assign access = bus_rd | bus_wr;

  // Only the two gaps count; register holes are not checked
  assign in_gap = ((bus_addr >= reset_cause_pkg::GAP1_LO) &&
                   (bus_addr <= reset_cause_pkg::GAP1_HI)) ||
                  ((bus_addr >= reset_cause_pkg::GAP2_LO) &&
                   (bus_addr <= reset_cause_pkg::GAP2_HI));

  // Level and pulse sources that request a reset
  assign ev_pin = ~st_ff.pin_sync[1];
  assign ev_wdog = watchdog_enable_option & (&st_ff.wdog_cnt);
  assign ev_bad_opcode = opcode_unimplemented |
                         (halt_instruction & ~halt_mode_enable) |
                         (background_entry_instruction &
                          ~background_mode_enable);
  assign ev_bad_addr = access & in_gap;
  assign ev_clk = clock_module_reset_req;
  assign ev_lowv = st_ff.lowv_sync[1] & low_voltage_reset_enable &
                   low_voltage_halt_enable;
  assign ev_pwr = st_ff.pwr_sync[1];
  // Only a background-sourced write may force reset
  assign ev_force = bus_wr & bus_bdm & (bus_addr == FORCE_ADDR) &
                    bus_wdata[reset_cause_pkg::FORCE_BIT];
  assign wdog_kick = bus_wr & (bus_addr == FLAGS_ADDR);

  // Cause bits laid out as in the flags register; force adds none
  always_comb begin
    events = 8'h00;
    events[reset_cause_pkg::POWER_ON_BIT] = ev_pwr;
    events[reset_cause_pkg::PIN_BIT] = ev_pin;
    events[reset_cause_pkg::WATCHDOG_BIT] = ev_wdog;
    events[reset_cause_pkg::ILL_OPCODE_BIT] = ev_bad_opcode;
    events[reset_cause_pkg::ILL_ADDRESS_BIT] = ev_bad_addr;
    events[reset_cause_pkg::CLOCK_MODULE_BIT] = ev_clk;
    events[reset_cause_pkg::LOW_VOLTAGE_BIT] = ev_lowv;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Synchronisers run through reset so sources are seen in it
    nxt_st.pin_sync = {st_ff.pin_sync[0], rst_pin_n};
    nxt_st.pwr_sync = {st_ff.pwr_sync[0], power_on_detect};
    nxt_st.lowv_sync = {st_ff.lowv_sync[0], low_voltage_detect};
    if (sys_rst) begin
      nxt_st.in_rst = 1'b1;
      nxt_st.reset_req = 1'b0;
      nxt_st.wdog_cnt = '0;
      nxt_st.rdata = reset_cause_pkg::READ_ZERO;
      // Power-on wipes every other pending cause
      if (ev_pwr) begin
        nxt_st.pending = 8'h00;
        nxt_st.pending[reset_cause_pkg::POWER_ON_BIT] = 1'b1;
      end else begin
        nxt_st.pending = st_ff.pending | events;
      end
    end else begin
      nxt_st.in_rst = 1'b0;
      // Any source or forced write asks for reset until it comes
      nxt_st.reset_req = st_ff.reset_req | (|events) | ev_force;
      // New events win over the clear at release
      nxt_st.pending = (release_now ? 8'h00 : st_ff.pending) | events;
      // Flags change only at release
      if (release_now) begin
        if (st_ff.pending[reset_cause_pkg::POWER_ON_BIT]) begin
          nxt_st.flags = reset_cause_pkg::POWER_ON_FLAGS;
        end else if (st_ff.pending[reset_cause_pkg::LOW_VOLTAGE_BIT]) begin
          nxt_st.flags = {st_ff.flags[7],
                          reset_cause_pkg::LOW_VOLTAGE_FLAGS};
        end else begin
          nxt_st.flags = {1'b0, st_ff.pending[6:2], 2'b00};
        end
      end
      // Watchdog counts only when enabled; kick clears it
      if (!watchdog_enable_option || wdog_kick) begin
        nxt_st.wdog_cnt = '0;
      end else if (!ev_wdog) begin
        nxt_st.wdog_cnt = st_ff.wdog_cnt + 1'b1;
      end
      // Read data, one cycle after the strobe
      nxt_st.rdata = reset_cause_pkg::READ_ZERO;
      if (bus_rd && (bus_addr == FLAGS_ADDR)) begin
        nxt_st.rdata = {st_ff.flags[7:1], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  // Outputs from flip-flops
  assign bus_rdata = st_ff.rdata;
  assign mcu_reset_req = st_ff.reset_req;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Forced reset leaves pending causes alone
  AST_FORCE_NO_FLAGS: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ev_force && events == 8'h00 && !release_now)
    |=> st_ff.pending == $past(st_ff.pending))
    else $error("forced reset changed pending causes");

  // Kick zeroes watchdog, flags hold
  AST_WDOG_KICK: assert property (
    @(posedge clk) disable iff (sys_rst)
    (wdog_kick && !release_now)
    |=> (st_ff.wdog_cnt == '0) && $stable(st_ff.flags))
    else $error("watchdog kick failed or flags moved");

  // Power-on release value
  AST_POWER_ON_FLAGS: assert property (
    @(posedge clk) disable iff (sys_rst)
    (release_now && st_ff.pending[7])
    |=> st_ff.flags == 8'h82)
    else $error("power-on flags wrong");

  // Low-voltage release keeps bit 7
  AST_LOW_VOLTAGE_FLAGS: assert property (
    @(posedge clk) disable iff (sys_rst)
    (release_now && !st_ff.pending[7] && st_ff.pending[1])
    |=> (st_ff.flags[7] == $past(st_ff.flags[7])) &&
        (st_ff.flags[6:0] == 7'h02))
    else $error("low-voltage flags wrong");

  // Other resets copy active sources
  AST_OTHER_FLAGS: assert property (
    @(posedge clk) disable iff (sys_rst)
    (release_now && !st_ff.pending[7] && !st_ff.pending[1])
    |=> st_ff.flags == {1'b0, $past(st_ff.pending[6:2]), 2'b00})
    else $error("other reset flags wrong");

  // Disabled watchdog never counts
  AST_WDOG_OFF: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!watchdog_enable_option)[*2] |-> (st_ff.wdog_cnt == '0) && !ev_wdog)
    else $error("watchdog ran while disabled");

  // Disallowed halt requests reset with opcode cause
  AST_HALT_ILLEGAL: assert property (
    @(posedge clk) disable iff (sys_rst)
    (halt_instruction && !halt_mode_enable)
    |=> st_ff.reset_req && st_ff.pending[4])
    else $error("illegal halt not caught");

  // Gap start is illegal
  AST_GAP_ACCESS: assert property (
    @(posedge clk) disable iff (sys_rst)
    (bus_rd && bus_addr == 16'h0470) |=> st_ff.pending[3] ##1 st_ff.reset_req)
    else $error("gap access not caught");

  // Register area holes are harmless
  AST_REG_HOLE: assert property (
    @(posedge clk) disable iff (sys_rst)
    (access && bus_addr >= 16'h1800 && bus_addr <= 16'h185F &&
     !release_now)
    |=> st_ff.pending[3] == $past(st_ff.pending[3]))
    else $error("register hole flagged illegal");

  // User writes to the force register do nothing
  AST_USER_FORCE: assert property (
    @(posedge clk) disable iff (sys_rst)
    (bus_wr && !bus_bdm && bus_addr == FORCE_ADDR && events == 8'h00 &&
     !st_ff.reset_req) |=> !st_ff.reset_req)
    else $error("user write forced reset");

  // Force register reads zero
  AST_FORCE_READ: assert property (
    @(posedge clk) disable iff (sys_rst)
    (bus_rd && bus_addr == FORCE_ADDR) |=> bus_rdata == 8'h00)
    else $error("force register read nonzero");

  // Background force write requests reset next cycle
  AST_FORCE_RESET: assert property (
    @(posedge clk) disable iff (sys_rst)
    ev_force |=> mcu_reset_req)
    else $error("forced reset not requested");

  // Flags read shows latched flags, bit 0 zero
  AST_FLAGS_READ: assert property (
    @(posedge clk) disable iff (sys_rst)
    (bus_rd && bus_addr == FLAGS_ADDR)
    |=> bus_rdata == {$past(st_ff.flags[7:1]), 1'b0})
    else $error("flags read wrong");

  // Disallowed background entry requests reset with opcode cause
  AST_BG_ILLEGAL: assert property (
    @(posedge clk) disable iff (sys_rst)
    (background_entry_instruction && !background_mode_enable)
    |=> st_ff.reset_req && st_ff.pending[4])
    else $error("illegal background entry not caught");

  // Unimplemented opcode requests reset with opcode cause
  AST_OPCODE_ILLEGAL: assert property (
    @(posedge clk) disable iff (sys_rst)
    opcode_unimplemented |=> st_ff.reset_req && st_ff.pending[4])
    else $error("unimplemented opcode not caught");

  // Synchronised low pin requests reset with pin cause
  AST_PIN_REQ: assert property (
    @(posedge clk) disable iff (sys_rst)
    !st_ff.pin_sync[1] |=> st_ff.reset_req && st_ff.pending[6])
    else $error("reset pin not caught");

  // Clock module request records its cause
  AST_CLOCK_REQ: assert property (
    @(posedge clk) disable iff (sys_rst)
    clock_module_reset_req |=> st_ff.reset_req && st_ff.pending[2])
    else $error("clock module request not caught");

  // Armed low voltage requests reset with voltage cause
  AST_LOW_VOLTAGE_REQ: assert property (
    @(posedge clk) disable iff (sys_rst)
    (st_ff.lowv_sync[1] && low_voltage_reset_enable &&
     low_voltage_halt_enable)
    |=> st_ff.reset_req && st_ff.pending[1])
    else $error("low voltage not caught");

  // Second gap is illegal from end to end
  AST_GAP2_ACCESS: assert property (
    @(posedge clk) disable iff (sys_rst)
    (access && bus_addr >= 16'h1860 && bus_addr <= 16'hBFFF)
    |=> st_ff.reset_req && st_ff.pending[3])
    else $error("second gap access not caught");

  // Expired enabled watchdog requests reset with its cause
  AST_WDOG_EXPIRE: assert property (
    @(posedge clk) disable iff (sys_rst)
    (watchdog_enable_option && (&st_ff.wdog_cnt))
    |=> st_ff.reset_req && st_ff.pending[5])
    else $error("watchdog expiry not caught");

  // Reset request stands until the system resets
  AST_REQ_HOLD: assert property (
    @(posedge clk) disable iff (sys_rst)
    mcu_reset_req |=> mcu_reset_req)
    else $error("reset request dropped early");

  // Read data is zero unless a read came the cycle before
  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (sys_rst)
    !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not zero when idle");

  // Bit 0 of read data is always zero
  AST_RDATA_BIT0: assert property (
    @(posedge clk) disable iff (sys_rst)
    bus_rdata[0] == 1'b0)
    else $error("read data bit 0 set");

endmodule

`default_nettype wire

// ### verification/debug_host_model.sv
// Debug host model issuing background single-byte writes
`timescale 1ns/1ps
`default_nettype none

module debug_host_model (
  // Clock
  input wire logic clk,
  // Command from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] cmd_data,
  // Background write onto the target bus
  output logic host_wr,
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata
);
  logic go_d = 1'b0;

  initial begin
    host_wr = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 8'h00;
  end

  // One background write strobe, prompt or a cycle late; idle bus scrambled
  always @(posedge clk) begin
    go_d <= go & slow;
    if ((go & ~slow) | go_d) begin
      host_wr <= 1'b1;
      host_addr <= reset_cause_pkg::FORCE_ADDR;
      host_wdata <= cmd_data;
    end else begin
      host_wr <= 1'b0;
      host_addr <= ~host_addr;
      host_wdata <= ~host_wdata;
    end
  end
endmodule

`default_nettype wire

// ### verification/reset_cause_tb.sv
// Self-checking bench for reset-cause flags and forced reset
`timescale 1ns/1ps
`default_nettype none

module reset_cause_tb;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic clk = 1'b0, sys_rst = 1'b1, rst_pin_n = 1'b1, pwr_on = 1'b1;
  logic low_v = 1'b0, lvre = 1'b0, lvse = 1'b0, wde = 1'b0;
  logic hme = 1'b0, bme = 1'b0, opu = 1'b0, hlt = 1'b0, bgi = 1'b0;
  logic ckr = 1'b0, tb_rd = 1'b0, tb_wr = 1'b0, tb_bdm = 1'b0;
  logic go = 1'b0, slow = 1'b0, rd_seen = 1'b0, host_wr;
  logic [15:0] tb_addr = 16'h0000, host_addr, bus_addr;
  logic [7:0] tb_wdata = 8'h00, cmd = 8'h00, host_wdata, bus_wdata;
  logic [7:0] bus_rdata, flags_now;
  logic bus_wr, bus_bdm, mcu_reset_req;
  logic [16:0] lfsr = 17'h1_173C;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int samples_checked = 0;

  // Bus shared by the bench and the debug host
  assign bus_wr = tb_wr | host_wr;
  assign bus_bdm = tb_bdm | host_wr;
  assign bus_addr = host_wr ? host_addr : tb_addr;
  assign bus_wdata = host_wr ? host_wdata : tb_wdata;

  always #50 clk = ~clk;

  reset_cause #(.WDOG_W(4)) uut (.clk(clk), .sys_rst(sys_rst),
    .rst_pin_n(rst_pin_n), .power_on_detect(pwr_on),
    .low_voltage_detect(low_v), .low_voltage_reset_enable(lvre),
    .low_voltage_halt_enable(lvse), .watchdog_enable_option(wde),
    .halt_mode_enable(hme), .background_mode_enable(bme),
    .opcode_unimplemented(opu), .halt_instruction(hlt),
    .background_entry_instruction(bgi), .clock_module_reset_req(ckr),
    .bus_addr(bus_addr), .bus_rd(tb_rd), .bus_wr(bus_wr),
    .bus_bdm(bus_bdm), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .mcu_reset_req(mcu_reset_req));

  debug_host_model host (.clk(clk), .go(go), .slow(slow), .cmd_data(cmd),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata));

  // -------------------------------------------------------------
  // Checking and helpers
  // -------------------------------------------------------------
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Read data compared against the oldest expectation
  always @(posedge clk) rd_seen <= tb_rd & ~sys_rst;
  always @(negedge clk) begin
    if (rd_seen) chk(bus_rdata, exp_q.pop_front());
  end

  // One-cycle read strobe with its expected answer queued
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    tb_rd = 1'b1;
    tb_addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    tb_rd = 1'b0;
  endtask

  // One-cycle write strobe, user or background
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic bdm);
    @(negedge clk);
    tb_wr = 1'b1;
    tb_addr = a;
    tb_wdata = d;
    tb_bdm = bdm;
    @(negedge clk);
    tb_wr = 1'b0;
    tb_bdm = 1'b0;
  endtask

  task automatic no_reset(input int n);
    repeat (n) begin
      @(negedge clk);
      chk(8'(mcu_reset_req), 8'h00);
    end
  endtask

  // System controller: hold reset, drop level sources midway
  task automatic sysreset();
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    {pwr_on, low_v, ckr, rst_pin_n} = 4'b0001;
    repeat (4) @(negedge clk);
    chk(8'(mcu_reset_req), 8'h00);
    sys_rst = 1'b0;
  endtask

  // Bounded wait for a reset request, then check latched flags
  task automatic expect_reset(input logic [7:0] f);
    int n;
    n = 0;
    while (mcu_reset_req !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(8'(mcu_reset_req), 8'h01);
    sysreset();
    flags_now = f;
    rd(reset_cause_pkg::FLAGS_ADDR, f);
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    pwr_on = 1'b0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    rd(reset_cause_pkg::FLAGS_ADDR, 8'h82);
    lvre = 1'b1;
    low_v = 1'b1;
    no_reset(6);
    lvse = 1'b1;
    expect_reset(8'h82);
    wr(reset_cause_pkg::FORCE_ADDR, 8'hFF, 1'b0);
    no_reset(4);
    rd(reset_cause_pkg::FORCE_ADDR, 8'h00);
    {go, cmd} = {1'b1, 8'hFE};
    @(negedge clk);
    go = 1'b0;
    no_reset(4);
    {go, slow, cmd} = {2'b11, 8'h01};
    @(negedge clk);
    go = 1'b0;
    expect_reset(8'h00);
    rst_pin_n = 1'b0;
    repeat (2) @(negedge clk);
    ckr = 1'b1;
    expect_reset(8'h44);
    low_v = 1'b1;
    expect_reset(8'h02);
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      {opu, hlt, bgi} = 3'b100 >> k;
      @(negedge clk);
      {opu, hlt, bgi} = 3'b000;
      expect_reset(8'h10);
    end
    {hme, bme} = 2'b11;
    @(negedge clk);
    {hlt, bgi} = 2'b11;
    @(negedge clk);
    {hlt, bgi} = 2'b00;
    no_reset(4);
    for (int k = 0; k < 4; k++) begin
      rd(k[1] ? (k[0] ? 16'hC000 : 16'h185F) : (k[0] ? 16'h1802 : 16'h046F),
         8'h00);
      no_reset(3);
      rd(k[1] ? (k[0] ? 16'hBFFF : 16'h1860) : (k[0] ? 16'h17FF : 16'h0470),
         8'h00);
      expect_reset(8'h08);
    end
    wde = 1'b1;
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      wr(reset_cause_pkg::FLAGS_ADDR, lfsr[7:0], 1'b0);
      no_reset(4);
    end
    rd(reset_cause_pkg::FLAGS_ADDR, flags_now);
    expect_reset(8'h20);
    wde = 1'b0;
    no_reset(30);
    test_done();
  end

  // Watchdog on the whole run
  initial begin
    #(100 * 5000);
    error_cnt++;
    test_done();
  end
endmodule

`default_nettype wire
